// ### rtl/eie_ctrl.sv
// External interrupt controller: edge detection, request flags, vector hand-off
//
// Notes on behaviour
// - Edge detection is blanked for one cycle on a direction or option register access.
// - An edge inside the blanked cycle is lost: no flag, no request.
// - Request coinciding with its flag clear may make the CPU fetch the reset vector.
// - Clearing an enable bit never trips the hazard path, but with an ack in the same cycle it yields the reset vector code.
`timescale 1ns/1ps
module eie_ctrl #(
    parameter int LINES = eie_pkg::LINES_DEF
) (
    input  wire logic               ref_clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    input  wire logic [LINES-1:0]   pin_i,
    input  wire logic [2*LINES-1:0] sens_i,
    input  wire logic               dir_access_i,
    input  wire logic               opt_access_i,
    input  wire logic [LINES-1:0]   enable_i,
    input  wire logic [LINES-1:0]   flag_clr_i,
    input  wire logic               global_mask_i,
    input  wire logic               ack_i,
    output logic                    irq_o,
    output logic [LINES-1:0]        flag_o,
    output logic [3:0]              vector_o,
    output logic                    vector_valid_o,
    output logic                    reset_fetch_o
);
    typedef enum logic [1:0] {
        EIE_IDLE,
        EIE_REQ,
        EIE_HAZARD
    } eie_state_e;

    // Lowest numbered pending line wins; returns its vector code
    function automatic logic [3:0] eie_pick(input logic [LINES-1:0] act);
        logic [3:0] v;
        v = eie_pkg::VEC_RESET;
        for (int i = LINES - 1; i >= 0; i--) begin
            if (act[i]) begin
                v = 4'(eie_pkg::VEC_LINE_BASE + 4'(i));
            end
        end
        return v;
    endfunction : eie_pick

    eie_edge_if #(.LINES(LINES)) edge_bus ();

    logic [LINES-1:0] flag_q;
    logic [LINES-1:0] flag_d;
    logic [LINES-1:0] active;
    logic             collide;
    eie_state_e       state_q;
    eie_state_e       state_d;
    logic             irq_q;
    logic             irq_d;
    logic [3:0]       vec_q;
    logic [3:0]       vec_d;
    logic             vvld_q;
    logic             vvld_d;
    logic             rfetch_q;
    logic             rfetch_d;

    // Any access to the port configuration blanks the detector
    assign edge_bus.pin   = pin_i;
    assign edge_bus.sens  = sens_i;
    assign edge_bus.blank = dir_access_i | opt_access_i;

    eie_edge_det #(.LINES(LINES)) u_det (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .e         (edge_bus.det_side)
    );

    // Flags: a new edge wins over a clear in the same cycle
    always_comb begin
        flag_d = (flag_q & ~flag_clr_i) | edge_bus.det;
    end

    // Active request is an enabled flag or an enabled edge arriving now
    assign active = enable_i & (flag_q | edge_bus.det);

    // Collision of an active request with its own flag clear; the enable
    // bit gates active, so dropping it can never trip this path
    assign collide = |(active & flag_clr_i) & ~global_mask_i;

    // Request and vector sequencing
    always_comb begin
        state_d  = state_q;
        irq_d    = irq_q;
        vec_d    = vec_q;
        vvld_d   = 1'b0;
        rfetch_d = 1'b0;
        case (state_q)
            EIE_IDLE: begin
                irq_d = |(enable_i & flag_q) & ~global_mask_i;
                if (collide) begin
                    // Source is lost while the CPU is already committed
                    state_d = EIE_HAZARD;
                    irq_d   = 1'b1;
                end else if (irq_d) begin
                    state_d = EIE_REQ;
                end
            end
            EIE_REQ: begin
                if (collide) begin
                    state_d = EIE_HAZARD;
                end else if (ack_i) begin
                    vec_d   = eie_pick(enable_i & flag_q);
                    vvld_d  = 1'b1;
                    irq_d   = 1'b0;
                    state_d = EIE_IDLE;
                end else if (global_mask_i || !(|(enable_i & flag_q))) begin
                    // Masking or disabling withdraws the request quietly
                    irq_d   = 1'b0;
                    state_d = EIE_IDLE;
                end
            end
            EIE_HAZARD: begin
                if (ack_i) begin
                    // Unrecognised source: the reset vector is handed over
                    vec_d    = eie_pkg::VEC_RESET;
                    vvld_d   = 1'b1;
                    rfetch_d = 1'b1;
                    irq_d    = 1'b0;
                    state_d  = EIE_IDLE;
                end
            end
            default: begin
                state_d = EIE_IDLE;
                irq_d   = 1'b0;
            end
        endcase
    end

    // All state frozen while the clock enable is low
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flag_q   <= {LINES{eie_pkg::FLAG_RST}};
            state_q  <= EIE_IDLE;
            irq_q    <= 1'b0;
            vec_q    <= eie_pkg::VEC_RESET;
            vvld_q   <= 1'b0;
            rfetch_q <= 1'b0;
        end else if (ce_i) begin
            flag_q   <= flag_d;
            state_q  <= state_d;
            irq_q    <= irq_d;
            vec_q    <= vec_d;
            vvld_q   <= vvld_d;
            rfetch_q <= rfetch_d;
        end
    end

    assign irq_o          = irq_q;
    assign flag_o         = flag_q;
    assign vector_o       = vec_q;
    assign vector_valid_o = vvld_q;
    assign reset_fetch_o  = rfetch_q;
endmodule : eie_ctrl

// ### rtl/eie_pkg.sv
// Constants shared by the external interrupt edge block
package eie_pkg;
    // Edge sensitivity encodings for each line
    localparam logic [1:0] SENS_FALL     = 2'h0;
    localparam logic [1:0] SENS_RISE     = 2'h1;
    localparam logic [1:0] SENS_BOTH     = 2'h2;
    localparam logic [1:0] SENS_NONE     = 2'h3;
    // Number of cycles the detector is blanked per configuration access
    localparam int         BLANK_CYCLES  = 1;
    // Default number of external lines
    localparam int         LINES_DEF     = 8;
    // Vector code handed to the CPU when the source is not recognised
    localparam logic [3:0] VEC_RESET     = 4'h0;
    // Vector code of line 0; line k uses VEC_LINE_BASE + k
    localparam logic [3:0] VEC_LINE_BASE = 4'h1;
    // Reset value of the request flags
    localparam logic       FLAG_RST      = 1'b0;
endpackage : eie_pkg

// ### rtl/eie_edge_if.sv
// Carrier between the controller and its edge detector
`timescale 1ns/1ps
interface eie_edge_if #(
    parameter int LINES = eie_pkg::LINES_DEF
);
    logic [LINES-1:0]   pin;
    logic [2*LINES-1:0] sens;
    logic               blank;
    logic [LINES-1:0]   det;
    modport ctrl (output pin, output sens, output blank, input det);
    modport det_side (input pin, input sens, input blank, output det);
endinterface : eie_edge_if

// ### rtl/eie_edge_det.sv
// Per-line edge detector with a blanking input
`timescale 1ns/1ps
module eie_edge_det #(
    parameter int LINES = eie_pkg::LINES_DEF
) (
    input  wire logic  ref_clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    eie_edge_if.det_side e
);
    logic [LINES-1:0] prev_q;
    logic [LINES-1:0] prev_d;

    // Previous level follows the pin in every enabled cycle, blanked or not, so a blanked edge is consumed
    always_comb begin
        prev_d = e.pin;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            prev_q <= '0;
        end else if (ce_i) begin
            prev_q <= prev_d;
        end
    end

    // Edge qualification per line
    generate
        for (genvar k = 0; k < LINES; k++) begin : g_line
            logic rise;
            logic fall;
            logic hit;
            assign rise = e.pin[k] & ~prev_q[k];
            assign fall = ~e.pin[k] & prev_q[k];
            always_comb begin
                case (e.sens[2*k +: 2])
                    eie_pkg::SENS_FALL: hit = fall;
                    eie_pkg::SENS_RISE: hit = rise;
                    eie_pkg::SENS_BOTH: hit = rise | fall;
                    default:            hit = 1'b0;
                endcase
            end
            // Blanked cycle: edge neither latched nor requested
            assign e.det[k] = hit & ~e.blank & ce_i;
        end
    endgenerate
endmodule : eie_edge_det

// ### tb/eie_pin_model.sv
// Pin source model for the external interrupt lines
`timescale 1ns/1ps
module eie_pin_model #(parameter int LINES = eie_pkg::LINES_DEF) (
    input  wire logic             ref_clk_i,
    input  wire logic [LINES-1:0] toggle_i,
    output logic      [LINES-1:0] pin_o
);
    // Lines idle high as with a pull-up; flips land on the clock edge
    initial pin_o = '1;
    always @(posedge ref_clk_i) pin_o <= pin_o ^ toggle_i;
endmodule : eie_pin_model

// ### tb/eie_ctrl_assertions.sv
// Concurrent checks on the controller ports
`timescale 1ns/1ps
module eie_ctrl_checker #(parameter int LINES = eie_pkg::LINES_DEF) (
    input wire logic               ref_clk_i,
    input wire logic               rst_i,
    input wire logic               ce_i,
    input wire logic [LINES-1:0]   pin_i,
    input wire logic [2*LINES-1:0] sens_i,
    input wire logic               dir_access_i,
    input wire logic               opt_access_i,
    input wire logic [LINES-1:0]   enable_i,
    input wire logic [LINES-1:0]   flag_clr_i,
    input wire logic               global_mask_i,
    input wire logic               ack_i,
    input wire logic               irq_o,
    input wire logic [LINES-1:0]   flag_o,
    input wire logic [3:0]         vector_o,
    input wire logic               vector_valid_o,
    input wire logic               reset_fetch_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // A blanked cycle must never raise a new flag
    blank_lost_a: assert property (
        ce_i && (dir_access_i || opt_access_i) |=> (flag_o & ~$past(flag_o)) == '0)
        else $error("flag rose from a blanked cycle");
    // Outside the blanked cycle a falling edge on line 0 is caught
    edge_caught_a: assert property (
        ce_i && $past(ce_i) && !$past(rst_i) && !(dir_access_i || opt_access_i)
        && sens_i[1:0] == eie_pkg::SENS_FALL && $fell(pin_i[0]) |=> flag_o[0])
        else $error("falling edge on line 0 not flagged");
    // A reset fetch is only ever reported with the reset vector code
    reset_vec_a: assert property (
        reset_fetch_o |-> vector_valid_o && vector_o == eie_pkg::VEC_RESET)
        else $error("reset fetch without reset vector");
    // A taken request hands a vector over and drops the request
    ack_hand_a: assert property (
        ack_i && irq_o |=> vector_valid_o && !irq_o)
        else $error("ack did not yield a vector");
    // A fresh request untouched by flag clears never fetches reset
    clean_take_a: assert property (
        $rose(irq_o) && flag_clr_i == '0 && $past(flag_clr_i) == '0 ##1
        ack_i && flag_clr_i == '0 |=> !reset_fetch_o)
        else $error("clean request fetched reset");
endmodule : eie_ctrl_checker
bind eie_ctrl eie_ctrl_checker #(.LINES(LINES)) chk_u (.*);

// ### tb/eie_ctrl_tb_top.sv
// Self-checking bench for the external interrupt controller
`timescale 1ns/1ps
module eie_ctrl_tb_top;
    logic       ref_clk_i = 1'b0, rst_i = 1'b1, dir_i = 1'b0, opt_i = 1'b0, ack_i = 1'b0;
    logic [7:0] tog = '0, en = '0, clr = '0, pin, flag, f, p;
    logic       msk = 1'b0;
    logic       irq, vval, rfetch;
    logic [3:0] vec;
    int         err_total = 0, n_checks = 0;
    eie_pin_model #(.LINES(8)) src_u (.ref_clk_i(ref_clk_i), .toggle_i(tog), .pin_o(pin));
    eie_ctrl #(.LINES(8)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .pin_i(pin), .sens_i({8{eie_pkg::SENS_FALL}}), .dir_access_i(dir_i),
        .opt_access_i(opt_i), .enable_i(en), .flag_clr_i(clr), .global_mask_i(msk),
        .ack_i(ack_i), .irq_o(irq), .flag_o(flag), .vector_o(vec),
        .vector_valid_o(vval), .reset_fetch_o(rfetch));
    initial forever #5 ref_clk_i = ~ref_clk_i;
    task automatic check_eq(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check_eq
    // Falls lines m; strobes sit on the edge cycle, or one cycle early
    task automatic edge_on(input logic [7:0] m, input logic d, o, early);
        @(posedge ref_clk_i) tog <= m;
        dir_i <= d & early;
        opt_i <= o & early;
        @(posedge ref_clk_i) tog <= '0;
        dir_i <= d & ~early;
        opt_i <= o & ~early;
        @(posedge ref_clk_i) dir_i <= 1'b0;
        opt_i <= 1'b0;
        #1 f = flag;
        p = pin;
        // Lines go back high; rises are ignored under falling sensitivity
        @(posedge ref_clk_i) tog <= m;
        @(posedge ref_clk_i) tog <= '0;
    endtask : edge_on
    task automatic clear(input logic [7:0] m);
        @(posedge ref_clk_i) clr <= m;
        @(posedge ref_clk_i) clr <= '0;
    endtask : clear
    // Waits for the request under a bound, takes it and judges the vector
    task automatic take(input logic [3:0] v, input logic r);
        int n = 0;
        do begin
            @(posedge ref_clk_i);
            #1 n++;
        end while (irq !== 1'b1 && n < 20);
        check_eq({7'h00, irq}, 8'h01);
        @(posedge ref_clk_i) ack_i <= 1'b1;
        @(posedge ref_clk_i) ack_i <= 1'b0;
        #1 check_eq({vval, rfetch, 2'h0, vec}, {1'b1, r, 2'h0, v});
    endtask : take
    task automatic t_blank;
        for (int i = 0; i < 2; i++) begin
            edge_on(8'h01, i == 0, i == 1, 1'b0);
            check_eq(f, 8'h00);
            #1 check_eq(flag, 8'h00);
            edge_on(8'h01, i == 0, i == 1, 1'b1);
            check_eq(f, 8'h01);
            clear(8'h01);
        end
        $display("blanking test done");
    endtask : t_blank
    task automatic t_hazard;
        en <= 8'h04;
        edge_on(8'h04, 1'b0, 1'b0, 1'b0);
        clear(8'h04);
        take(eie_pkg::VEC_RESET, 1'b1);
        $display("flag clear hazard test done");
    endtask : t_hazard
    task automatic t_mask_drop;
        edge_on(8'h04, 1'b0, 1'b0, 1'b0);
        @(posedge ref_clk_i) en <= 8'h00;
        @(posedge ref_clk_i) en <= 8'h04;
        take(eie_pkg::VEC_LINE_BASE + 4'h2, 1'b0);
        // Clear only while the line is disabled, so no hazard arises
        @(posedge ref_clk_i) en <= 8'h00;
        clear(8'h04);
        $display("enable drop test done");
    endtask : t_mask_drop
    // Flag cleared inside a mask bracket: no request and no reset fetch follow
    task automatic t_mask_clear;
        en <= 8'h04;
        edge_on(8'h04, 1'b0, 1'b0, 1'b0);
        @(posedge ref_clk_i) msk <= 1'b1;
        clear(8'h04);
        msk <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        #1 check_eq({irq, rfetch, 6'h00}, 8'h00);
        check_eq(flag, 8'h00);
        en <= 8'h00;
        $display("masked clear test done");
    endtask : t_mask_clear
    // Software recovery of an edge lost in the blanked cycle, masked or not
    task automatic t_soft_recover(input logic masked);
        logic lvl_pre, lvl_post, sema;
        int   pushes;
        pushes = 0;
        @(posedge ref_clk_i) msk <= masked;
        sema = ~masked;
        lvl_pre = pin[0];
        edge_on(8'h01, 1'b1, 1'b0, 1'b0);
        lvl_post = p[0];
        if (masked && lvl_pre && !lvl_post) sema = 1'b1;
        @(posedge ref_clk_i) msk <= 1'b0;
        if (lvl_pre && !lvl_post && sema) pushes = 3;
        check_eq(8'(pushes), 8'h03);
        #1 check_eq(flag, 8'h00);
        $display("software recovery test done");
    endtask : t_soft_recover
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_blank();
        t_hazard();
        t_mask_drop();
        t_mask_clear();
        t_soft_recover(1'b0);
        t_soft_recover(1'b1);
        report_and_stop();
    end
    // Watchdog: the tests need a few hundred cycles at most
    initial begin
        #20000;
        err_total++;
        report_and_stop();
    end
endmodule : eie_ctrl_tb_top
